// >>> pkg/mpio_pkg.sv
// Shared constants, register map and carrier types of the parallel port block.
package mpio_pkg;

  localparam int DW = 8;
  localparam int AW = 8;

  // Register map; 0x06, 0x0A, 0x0B and 0x0C are fixed, the rest fill the gaps.
  localparam logic [AW-1:0] OFF_OSC_LATCH   = 8'h02;
  localparam logic [AW-1:0] OFF_TIMER_LATCH = 8'h03;
  localparam logic [AW-1:0] OFF_SEG_A_LATCH = 8'h05;
  localparam logic [AW-1:0] OFF_ANA_LATCH   = 8'h06;
  localparam logic [AW-1:0] OFF_SEG_B_LATCH = 8'h07;
  localparam logic [AW-1:0] OFF_OSC_PIN     = 8'h08;
  localparam logic [AW-1:0] OFF_TIMER_PIN   = 8'h0A;
  localparam logic [AW-1:0] OFF_SEG_A_PIN   = 8'h0B;
  localparam logic [AW-1:0] OFF_ANA_DIR     = 8'h0C;
  localparam logic [AW-1:0] OFF_SEG_B_PIN   = 8'h0D;
  localparam logic [AW-1:0] OFF_CTL         = 8'h10;
  localparam logic [AW-1:0] OFF_TIMER_TYPE  = 8'h11;
  localparam logic [AW-1:0] OFF_SEG_A_LCD   = 8'h12;
  localparam logic [AW-1:0] OFF_SEG_B_LCD   = 8'h13;
  localparam logic [AW-1:0] OFF_STATUS      = 8'h14;

  // Valid bits of the narrow ports; the bits above read as zero.
  localparam logic [DW-1:0] OSC_MASK   = 8'h07;
  localparam logic [DW-1:0] TIMER_MASK = 8'h0F;

  // Control register fields.
  localparam int CTL_DUAL_CLOCK = 0;
  localparam int CTL_AIN_DISABLE = 1;
  localparam int CTL_OUT_ENABLE = 2;
  // Status register field: falling edge latch of osc port bit 0, write one to clear.
  localparam int STAT_FALL = 0;

  localparam logic [DW-1:0] RST_ONES = 8'hFF;
  localparam logic [DW-1:0] RST_ZERO = 8'h00;
  localparam logic [DW-1:0] RST_CTL  = 8'h06;

  typedef struct packed {
    logic            wr;
    logic            rd;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wdata;
  } mpio_bus_req_t;

  typedef struct packed {
    logic [DW-1:0] osc_latch;
    logic [DW-1:0] timer_latch;
    logic [DW-1:0] timer_type;
    logic [DW-1:0] seg_a_latch;
    logic [DW-1:0] seg_a_lcd;
    logic [DW-1:0] seg_b_latch;
    logic [DW-1:0] seg_b_lcd;
    logic [DW-1:0] ana_latch;
    logic [DW-1:0] ana_dir;
    logic [DW-1:0] ctl;
    logic [DW-1:0] rdata;
  } mpio_state_t;

endpackage

// >>> hw/mpio_pin_drv.sv
// Registered pin driver with per-bit push-pull or sink-only open-drain choice.
`timescale 1ns/100ps
module mpio_pin_drv #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic [W-1:0] push_pull_in,
  input  wire logic [W-1:0] enable_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_out
);

  typedef struct packed {
    logic [W-1:0] o;
    logic [W-1:0] oe;
  } mpio_drv_state_t;

  mpio_drv_state_t r;
  mpio_drv_state_t next_r;

  // Open drain only sinks: a one releases the pin to the outside pull-up.
  always_comb begin
    next_r.o  = value_in & push_pull_in & enable_in;
    next_r.oe = enable_in & (push_pull_in | ~value_in);
  end

  // Reset leaves every pin released until the latches have been applied.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pin_out    = r.o;
  assign pin_oe_out = r.oe;

endmodule

// >>> hw/mpio_fall_latch.sv
// Sticky latch that is set by a falling edge and cleared by a software pulse.
`timescale 1ns/100ps
module mpio_fall_latch (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic level_in,
  input  wire logic clear_in,
  output logic      flag_out
);

  typedef struct packed {
    logic armed;
    logic prev;
    logic flag;
  } mpio_fall_state_t;

  mpio_fall_state_t r;
  mpio_fall_state_t next_r;

  // The first cycle after reset only samples, so a low pin is not taken for an edge.
  always_comb begin
    next_r.armed = 1'b1;
    next_r.prev  = level_in;
    // A new edge in the clearing cycle wins over the clear.
    next_r.flag  = (r.flag & ~clear_in) | (r.armed & r.prev & ~level_in);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign flag_out = r.flag;

endmodule

// >>> hw/mpio_top.sv
// Parallel port block: oscillator, timer, two segment and one analog port.
//
// What the document requires
// RL1: Osc port latch resets ones; inputs need one.
// RL2: Software writes one for osc port inputs.
// RL3: Dual-clock mode gives osc bits 1-2 crystal.
// RL4: Osc bit 0 falling edge sets latch.
// RL5: Osc pin read: bits 7-3 undefined.
// RL6: Stop mode floats osc bit 0 always.
// RL7: Driver type: 0 open drain, 1 push-pull.
// RL8: Timer latch resets ones, type zero.
// RL9: Software sets latch before clearing type.
// RL10: Timer pin read: bits 7-4 undefined.
// RL11: Segment A select one routes LCD.
// RL12: Segment B select one routes LCD.
// RL13: LCD segment bits read undefined pin data.
// RL14: Analog port resets direction, data zero.
// RL15: Direction and data choose analog port mode.
// RL16: Analog-mode bits read as zero.
// RL17: Software configures wake, interrupt, counter inputs.
// RL18: No read-modify-write on analog data latch.
// RL19: Software sets segment latch for inputs.
// RL20: Writes update latch; pin follows latch.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module mpio_top (
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  input  wire mpio_pkg::mpio_bus_req_t bus_in,
  output logic [mpio_pkg::DW-1:0]    rdata_out,
  input  wire logic                  stop_mode_in,
  input  wire logic [2:0]            osc_pin_in,
  output logic      [2:0]            osc_pin_out,
  output logic      [2:0]            osc_pin_oe_out,
  output logic                       low_freq_crystal_en_out,
  output logic                       osc_fall_latch_out,
  input  wire logic [3:0]            timer_pin_in,
  output logic      [3:0]            timer_pin_out,
  output logic      [3:0]            timer_pin_oe_out,
  input  wire logic [3:0]            timer_alt_data_in,
  input  wire logic [3:0]            timer_alt_en_in,
  input  wire logic [7:0]            seg_a_pin_in,
  output logic      [7:0]            seg_a_pin_out,
  output logic      [7:0]            seg_a_pin_oe_out,
  input  wire logic [7:0]            seg_a_lcd_data_in,
  input  wire logic [7:0]            seg_b_pin_in,
  output logic      [7:0]            seg_b_pin_out,
  output logic      [7:0]            seg_b_pin_oe_out,
  input  wire logic [7:0]            seg_b_lcd_data_in,
  input  wire logic [7:0]            ana_pin_in,
  output logic      [7:0]            ana_pin_out,
  output logic      [7:0]            ana_pin_oe_out,
  output logic      [7:0]            ana_select_out,
  output logic      [7:0]            ana_func_out
);

  mpio_pkg::mpio_state_t r;
  mpio_pkg::mpio_state_t next_r;

  logic       dual_clock;
  logic       ain_disable;
  logic       out_allowed;
  logic       fall_clear;
  logic [2:0] osc_enable;
  logic [3:0] timer_value;
  logic [7:0] seg_a_value;
  logic [7:0] seg_b_value;
  logic [7:0] ana_input_mode;

  // Output-mode bits show the latch, input-mode bits the pin, analog or fixed bits zero.
  function automatic logic [7:0] ana_read(input logic [7:0] dir,
                                          input logic [7:0] latch,
                                          input logic [7:0] pin);
    ana_read = (dir & latch) | (~dir & latch & pin); // [RL16] [RL15]
  endfunction

  // Pin data of a segment port with the LCD-driven bits read as zero.
  function automatic logic [7:0] seg_read(input logic [7:0] lcd,
                                          input logic [7:0] pin);
    seg_read = pin & ~lcd; // [RL13]
  endfunction

  assign dual_clock  = r.ctl[mpio_pkg::CTL_DUAL_CLOCK];
  assign ain_disable = r.ctl[mpio_pkg::CTL_AIN_DISABLE];
  // In stop mode the global enable decides whether pins other than osc bit 0 keep driving.
  assign out_allowed = ~stop_mode_in | r.ctl[mpio_pkg::CTL_OUT_ENABLE];
  assign fall_clear  = bus_in.wr & (bus_in.addr == mpio_pkg::OFF_STATUS)
                     & bus_in.wdata[mpio_pkg::STAT_FALL];

  always_comb begin
    next_r = r;
    if (bus_in.wr) begin
      case (bus_in.addr)
        mpio_pkg::OFF_OSC_LATCH:   next_r.osc_latch   = bus_in.wdata; // [RL20]
        mpio_pkg::OFF_TIMER_LATCH: next_r.timer_latch = bus_in.wdata; // [RL20]
        mpio_pkg::OFF_TIMER_TYPE:  next_r.timer_type  = bus_in.wdata;
        mpio_pkg::OFF_SEG_A_LATCH: next_r.seg_a_latch = bus_in.wdata; // [RL20]
        mpio_pkg::OFF_SEG_A_LCD:   next_r.seg_a_lcd   = bus_in.wdata;
        mpio_pkg::OFF_SEG_B_LATCH: next_r.seg_b_latch = bus_in.wdata; // [RL20]
        mpio_pkg::OFF_SEG_B_LCD:   next_r.seg_b_lcd   = bus_in.wdata;
        mpio_pkg::OFF_ANA_LATCH:   next_r.ana_latch   = bus_in.wdata; // [RL20]
        mpio_pkg::OFF_ANA_DIR:     next_r.ana_dir     = bus_in.wdata;
        mpio_pkg::OFF_CTL:         next_r.ctl         = bus_in.wdata;
        default: begin
        end
      endcase
    end
    next_r.rdata = mpio_pkg::RST_ZERO;
    if (bus_in.rd) begin
      case (bus_in.addr)
        mpio_pkg::OFF_OSC_LATCH:   next_r.rdata = r.osc_latch & mpio_pkg::OSC_MASK;
        mpio_pkg::OFF_OSC_PIN:     next_r.rdata = {5'h00, osc_pin_in}; // [RL5]
        mpio_pkg::OFF_TIMER_LATCH: next_r.rdata = r.timer_latch & mpio_pkg::TIMER_MASK;
        mpio_pkg::OFF_TIMER_TYPE:  next_r.rdata = r.timer_type & mpio_pkg::TIMER_MASK;
        mpio_pkg::OFF_TIMER_PIN:   next_r.rdata = {4'h0, timer_pin_in}; // [RL10]
        mpio_pkg::OFF_SEG_A_LATCH: next_r.rdata = r.seg_a_latch;
        mpio_pkg::OFF_SEG_A_LCD:   next_r.rdata = r.seg_a_lcd;
        mpio_pkg::OFF_SEG_A_PIN:   next_r.rdata = seg_read(r.seg_a_lcd, seg_a_pin_in);
        mpio_pkg::OFF_SEG_B_LATCH: next_r.rdata = r.seg_b_latch;
        mpio_pkg::OFF_SEG_B_LCD:   next_r.rdata = r.seg_b_lcd;
        mpio_pkg::OFF_SEG_B_PIN:   next_r.rdata = seg_read(r.seg_b_lcd, seg_b_pin_in);
        // Input bits return the pin, so a read-modify-write would corrupt the modes.
        mpio_pkg::OFF_ANA_LATCH:   next_r.rdata = ana_read(r.ana_dir, r.ana_latch,
                                                           ana_pin_in); // [RL18]
        mpio_pkg::OFF_ANA_DIR:     next_r.rdata = r.ana_dir;
        mpio_pkg::OFF_CTL:         next_r.rdata = r.ctl;
        mpio_pkg::OFF_STATUS:      next_r.rdata = {7'h00, osc_fall_latch_out};
        default:                   next_r.rdata = mpio_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r.osc_latch   <= mpio_pkg::RST_ONES; // [RL1]
      r.timer_latch <= mpio_pkg::RST_ONES; // [RL8]
      r.timer_type  <= mpio_pkg::RST_ZERO; // [RL8]
      r.seg_a_latch <= mpio_pkg::RST_ONES; // [RL11]
      r.seg_a_lcd   <= mpio_pkg::RST_ZERO;
      r.seg_b_latch <= mpio_pkg::RST_ONES; // [RL12]
      r.seg_b_lcd   <= mpio_pkg::RST_ZERO;
      r.ana_latch   <= mpio_pkg::RST_ZERO; // [RL14]
      r.ana_dir     <= mpio_pkg::RST_ZERO; // [RL14]
      r.ctl         <= mpio_pkg::RST_CTL;  // [RL14]
      r.rdata       <= mpio_pkg::RST_ZERO;
    end else begin
      r <= next_r;
    end
  end

  assign rdata_out = r.rdata;

  // Oscillator port: crystal pins released in dual-clock mode, bit 0 floats in stop.
  assign osc_enable[0]   = ~stop_mode_in; // [RL6]
  assign osc_enable[2:1] = {2{~dual_clock & out_allowed}}; // [RL3]
  assign low_freq_crystal_en_out = dual_clock; // [RL3]

  mpio_pin_drv #(.W(3)) u_osc_drv (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .value_in     (r.osc_latch[2:0]),
    .push_pull_in (3'h0),
    .enable_in    (osc_enable),
    .pin_out      (osc_pin_out),
    .pin_oe_out   (osc_pin_oe_out)
  );

  // The pin is watched, so an output pulse on bit 0 also sets the latch.
  mpio_fall_latch u_osc_fall (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .level_in (osc_pin_in[0]),
    .clear_in (fall_clear),
    .flag_out (osc_fall_latch_out)
  ); // [RL4]

  // Timer port: the timer or divider output only shows while the latch is one.
  assign timer_value = r.timer_latch[3:0] & (timer_alt_data_in | ~timer_alt_en_in); // [RL9]

  mpio_pin_drv #(.W(4)) u_timer_drv (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .value_in     (timer_value),
    .push_pull_in (r.timer_type[3:0]), // [RL7]
    .enable_in    ({4{out_allowed}}),
    .pin_out      (timer_pin_out),
    .pin_oe_out   (timer_pin_oe_out)
  );

  // Segment ports: LCD bits are driven hard, port bits are open drain.
  assign seg_a_value = (r.seg_a_lcd & seg_a_lcd_data_in)
                     | (~r.seg_a_lcd & r.seg_a_latch); // [RL11]
  assign seg_b_value = (r.seg_b_lcd & seg_b_lcd_data_in)
                     | (~r.seg_b_lcd & r.seg_b_latch); // [RL12]

  mpio_pin_drv #(.W(8)) u_seg_a_drv (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .value_in     (seg_a_value),
    .push_pull_in (r.seg_a_lcd),
    .enable_in    ({8{out_allowed}}),
    .pin_out      (seg_a_pin_out),
    .pin_oe_out   (seg_a_pin_oe_out)
  );

  mpio_pin_drv #(.W(8)) u_seg_b_drv (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .value_in     (seg_b_value),
    .push_pull_in (r.seg_b_lcd),
    .enable_in    ({8{out_allowed}}),
    .pin_out      (seg_b_pin_out),
    .pin_oe_out   (seg_b_pin_oe_out)
  );

  // Analog port: direction one drives, direction zero with latch zero is analog or fixed.
  assign ana_input_mode = ~r.ana_dir & r.ana_latch; // [RL15]
  assign ana_select_out = ~r.ana_dir & ~r.ana_latch & {8{~ain_disable}}; // [RL15]
  assign ana_func_out   = (ana_input_mode | r.ana_dir) & ana_pin_in; // [RL14]

  mpio_pin_drv #(.W(8)) u_ana_drv (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .value_in     (r.ana_latch),
    .push_pull_in (mpio_pkg::RST_ONES),
    .enable_in    (r.ana_dir & {8{out_allowed}}), // [RL15]
    .pin_out      (ana_pin_out),
    .pin_oe_out   (ana_pin_oe_out)
  );

  // Drivers are registered, so the pin checks compare with the controls one edge back.
  a_osc_reset_ones: assert property (@(posedge clk_in) // [RL1]
    $past(srst_in) && !srst_in
    |-> r.osc_latch == mpio_pkg::RST_ONES)
    else $error("osc latch not all ones after reset");

  a_crystal_pins_free: assert property (@(posedge clk_in) disable iff (srst_in) // [RL3]
    $past(dual_clock) && !$past(srst_in)
    |-> osc_pin_oe_out[2:1] == 2'h0)
    else $error("crystal pins driven in dual-clock mode");

  a_fall_sets_latch: assert property (@(posedge clk_in) disable iff (srst_in) // [RL4]
    $past(!srst_in) && $fell(osc_pin_in[0])
    |=> osc_fall_latch_out)
    else $error("falling edge on osc bit 0 not latched");

  a_osc_pin_upper: assert property (@(posedge clk_in) disable iff (srst_in) // [RL5]
    bus_in.rd && bus_in.addr == mpio_pkg::OFF_OSC_PIN
    |=> rdata_out[7:3] == 5'h00)
    else $error("osc pin read upper bits not zero");

  a_stop_floats_bit0: assert property (@(posedge clk_in) disable iff (srst_in) // [RL6]
    stop_mode_in
    |=> !osc_pin_oe_out[0])
    else $error("osc bit 0 driven during stop mode");

  a_open_drain_sinks: assert property (@(posedge clk_in) disable iff (srst_in) // [RL7]
    !$past(srst_in)
    |-> (timer_pin_out & ~$past(r.timer_type[3:0])) == 4'h0)
    else $error("open-drain timer pin driven high");

  a_push_pull_drives: assert property (@(posedge clk_in) disable iff (srst_in) // [RL7]
    !$past(srst_in) && $past(out_allowed)
    |-> (~timer_pin_oe_out & $past(r.timer_type[3:0])) == 4'h0)
    else $error("push-pull timer pin not driven");

  a_timer_reset: assert property (@(posedge clk_in) // [RL8]
    $past(srst_in) && !srst_in
    |-> r.timer_type == mpio_pkg::RST_ZERO && r.timer_latch == mpio_pkg::RST_ONES)
    else $error("timer port reset values wrong");

  a_timer_pin_upper: assert property (@(posedge clk_in) disable iff (srst_in) // [RL10]
    bus_in.rd && bus_in.addr == mpio_pkg::OFF_TIMER_PIN
    |=> rdata_out[7:4] == 4'h0)
    else $error("timer pin read upper bits not zero");

  a_seg_a_lcd: assert property (@(posedge clk_in) disable iff (srst_in) // [RL11]
    !$past(srst_in) && $past(out_allowed)
    |-> ((~seg_a_pin_oe_out | (seg_a_pin_out ^ $past(seg_a_lcd_data_in)))
         & $past(r.seg_a_lcd)) == 8'h00)
    else $error("segment A LCD pin not driven from segment data");

  a_seg_b_lcd: assert property (@(posedge clk_in) disable iff (srst_in) // [RL12]
    !$past(srst_in) && $past(out_allowed)
    |-> ((~seg_b_pin_oe_out | (seg_b_pin_out ^ $past(seg_b_lcd_data_in)))
         & $past(r.seg_b_lcd)) == 8'h00)
    else $error("segment B LCD pin not driven from segment data");

  a_seg_read_lcd: assert property (@(posedge clk_in) disable iff (srst_in) // [RL13]
    bus_in.rd && bus_in.addr == mpio_pkg::OFF_SEG_A_PIN
    |=> (rdata_out & $past(r.seg_a_lcd)) == 8'h00)
    else $error("LCD segment bit read as one");

  a_ana_reset: assert property (@(posedge clk_in) // [RL14]
    $past(srst_in) && !srst_in
    |-> r.ana_dir == mpio_pkg::RST_ZERO && ain_disable && ana_func_out == 8'h00)
    else $error("analog port reset state wrong");

  a_ana_drive: assert property (@(posedge clk_in) disable iff (srst_in) // [RL15]
    !$past(srst_in)
    |-> ana_pin_oe_out == ($past(r.ana_dir) & {8{$past(out_allowed)}}))
    else $error("analog port drive does not follow direction");

  a_ana_read_zero: assert property (@(posedge clk_in) disable iff (srst_in) // [RL16]
    bus_in.rd && bus_in.addr == mpio_pkg::OFF_ANA_LATCH
    |=> (rdata_out & ~$past(r.ana_dir) & ~$past(r.ana_latch)) == 8'h00)
    else $error("analog-mode bit read as one");

  a_latch_to_pin: assert property (@(posedge clk_in) disable iff (srst_in) // [RL20]
    bus_in.wr && bus_in.addr == mpio_pkg::OFF_ANA_LATCH ##1 !stop_mode_in
    |=> ((ana_pin_out ^ $past(r.ana_latch)) & $past(r.ana_dir)) == 8'h00)
    else $error("analog output pin does not follow latch");

  c_dual_clock: cover property (@(posedge clk_in) disable iff (srst_in)
    $rose(dual_clock));

  c_fall_latched: cover property (@(posedge clk_in) disable iff (srst_in)
    $rose(osc_fall_latch_out));

  c_analog_select: cover property (@(posedge clk_in) disable iff (srst_in)
    ana_select_out != 8'h00);

  c_push_pull: cover property (@(posedge clk_in) disable iff (srst_in)
    timer_pin_oe_out == 4'hF && timer_pin_out != 4'h0);

  c_outputs_held: cover property (@(posedge clk_in) disable iff (srst_in)
    !out_allowed);

endmodule

// >>> testbench/mpio_pin_world.sv
// Far side of the port pins: a pull-up on every pin plus an optional external driver.
`timescale 1ns/100ps
module mpio_pin_world #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] val_in,
  input  wire logic [W-1:0] ext_en_in,
  input  wire logic [W-1:0] ext_val_in,
  output logic      [W-1:0] level_out
);
  // Two drivers that disagree give an unknown level, so a driver that should be off shows up.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe_in[i] && ext_en_in[i]) begin
        level_out[i] = (val_in[i] === ext_val_in[i]) ? val_in[i] : 1'bx;
      end else if (oe_in[i]) begin
        level_out[i] = val_in[i];
      end else if (ext_en_in[i]) begin
        level_out[i] = ext_val_in[i];
      end else begin
        level_out[i] = 1'b1;
      end
    end
  end
endmodule

// >>> testbench/tb.sv
// Self-checking bench: random register and pin traffic against a behavioural model.
`timescale 1ns/100ps
module tb;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  mpio_pkg::mpio_bus_req_t bus_in = '0;
  logic [7:0] rdata, ee_osc, xe_osc, ee_tim, xe_tim, ee_sa, xe_sa, ee_sb, xe_sb, ee_an, xe_an;
  logic [7:0] lcd_a = 8'h00, lcd_b = 8'h00, an_sel, an_func, sa_o, sa_oe, sb_o, sb_oe, an_o, an_oe;
  logic [7:0] lv_sa, lv_sb, lv_an;
  logic [3:0] alt_d = 4'h0, alt_e = 4'h0, tim_o, tim_oe, lv_tim;
  logic [2:0] osc_o, osc_oe, lv_osc;
  logic       stop_mode = 1'b0, xtal_en, fall_flag, m_flag, prev0;
  logic [7:0] m_osc, m_tl, m_tt, m_sa, m_sal, m_sb, m_sbl, m_al, m_ad, m_ctl;
  logic [7:0] d_osc, d_tim, d_sa, d_sb, v_sa, v_sb, tv, l_osc, l_tim, l_sa, l_sb, l_an, en;
  logic [7:0] wl[$], rl[$];
  int         miscompares = 0, check_count = 0;

  always #20 clk_in = ~clk_in;

  mpio_top u_mpio_top (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus_in), .rdata_out(rdata),
    .stop_mode_in(stop_mode), .osc_pin_in(lv_osc), .osc_pin_out(osc_o), .osc_pin_oe_out(osc_oe),
    .low_freq_crystal_en_out(xtal_en), .osc_fall_latch_out(fall_flag), .timer_pin_in(lv_tim),
    .timer_pin_out(tim_o), .timer_pin_oe_out(tim_oe), .timer_alt_data_in(alt_d),
    .timer_alt_en_in(alt_e), .seg_a_pin_in(lv_sa), .seg_a_pin_out(sa_o), .seg_a_pin_oe_out(sa_oe),
    .seg_a_lcd_data_in(lcd_a), .seg_b_pin_in(lv_sb), .seg_b_pin_out(sb_o),
    .seg_b_pin_oe_out(sb_oe), .seg_b_lcd_data_in(lcd_b), .ana_pin_in(lv_an), .ana_pin_out(an_o),
    .ana_pin_oe_out(an_oe), .ana_select_out(an_sel), .ana_func_out(an_func));
  mpio_pin_world #(.W(3)) u_w_osc (.oe_in(osc_oe), .val_in(osc_o), .ext_en_in(ee_osc[2:0]),
    .ext_val_in(xe_osc[2:0]), .level_out(lv_osc));
  mpio_pin_world #(.W(4)) u_w_tim (.oe_in(tim_oe), .val_in(tim_o), .ext_en_in(ee_tim[3:0]),
    .ext_val_in(xe_tim[3:0]), .level_out(lv_tim));
  mpio_pin_world #(.W(8)) u_w_sa (.oe_in(sa_oe), .val_in(sa_o), .ext_en_in(ee_sa),
    .ext_val_in(xe_sa), .level_out(lv_sa));
  mpio_pin_world #(.W(8)) u_w_sb (.oe_in(sb_oe), .val_in(sb_o), .ext_en_in(ee_sb),
    .ext_val_in(xe_sb), .level_out(lv_sb));
  mpio_pin_world #(.W(8)) u_w_an (.oe_in(an_oe), .val_in(an_o), .ext_en_in(ee_an),
    .ext_val_in(xe_an), .level_out(lv_an));

  task automatic close_out();
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g,
                     input logic [7:0] m);
    check_count++;
    if ((g & m) !== (e & m)) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask

  function automatic logic [7:0] lvl(input logic [7:0] d, v, e, x);
    return (d & v) | (~d & ((e & x) | ~e));
  endfunction

  // Expected pin levels follow from the model registers and what the far side drives.
  task automatic calc();
    // Out-enable low in stop mode releases every driver except osc bit 0.
    en = {8{~stop_mode | m_ctl[mpio_pkg::CTL_OUT_ENABLE]}};
    d_osc = {5'h00, ~m_osc[2:0] & {{2{~m_ctl[0] & en[0]}}, ~stop_mode}};
    tv = {4'h0, m_tl[3:0] & ((alt_e & alt_d) | ~alt_e)};
    d_tim = ({4'h0, m_tt[3:0]} | ~tv) & en;
    d_sa = (m_sal | ~m_sa) & en;
    v_sa = (m_sal & lcd_a) | (~m_sal & m_sa);
    d_sb = (m_sbl | ~m_sb) & en;
    v_sb = (m_sbl & lcd_b) | (~m_sbl & m_sb);
    l_osc = lvl(d_osc, 8'h00, ee_osc, xe_osc);
    l_tim = lvl(d_tim, tv, ee_tim, xe_tim);
    l_sa = lvl(d_sa, v_sa, ee_sa, xe_sa);
    l_sb = lvl(d_sb, v_sb, ee_sb, xe_sb);
    l_an = lvl(m_ad & en, m_al, ee_an, xe_an);
    if (prev0 && !l_osc[0]) m_flag = 1'b1;
    prev0 = l_osc[0];
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      mpio_pkg::OFF_OSC_LATCH:   return m_osc & mpio_pkg::OSC_MASK;
      mpio_pkg::OFF_TIMER_LATCH: return m_tl & mpio_pkg::TIMER_MASK;
      mpio_pkg::OFF_SEG_A_LATCH: return m_sa;
      mpio_pkg::OFF_ANA_LATCH:   return (m_ad & m_al) | (~m_ad & m_al & l_an);
      mpio_pkg::OFF_SEG_B_LATCH: return m_sb;
      mpio_pkg::OFF_OSC_PIN:     return l_osc & mpio_pkg::OSC_MASK;
      mpio_pkg::OFF_TIMER_PIN:   return l_tim & mpio_pkg::TIMER_MASK;
      mpio_pkg::OFF_SEG_A_PIN:   return l_sa & ~m_sal;
      mpio_pkg::OFF_ANA_DIR:     return m_ad;
      mpio_pkg::OFF_SEG_B_PIN:   return l_sb & ~m_sbl;
      mpio_pkg::OFF_CTL:         return m_ctl;
      mpio_pkg::OFF_TIMER_TYPE:  return m_tt;
      mpio_pkg::OFF_SEG_A_LCD:   return m_sal;
      mpio_pkg::OFF_SEG_B_LCD:   return m_sbl;
      mpio_pkg::OFF_STATUS:      return {7'h00, m_flag};
      default:                   return 8'h00;
    endcase
  endfunction

  // Only the documented bits of control, type and status are compared, and only osc pin bit 0 in dual-clock mode.
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      mpio_pkg::OFF_CTL:        return 8'h07;
      mpio_pkg::OFF_TIMER_TYPE: return 8'h0F;
      mpio_pkg::OFF_STATUS:     return 8'h01;
      mpio_pkg::OFF_OSC_PIN:    return m_ctl[0] ? 8'h01 : 8'h07;
      default:                  return 8'hFF;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    bus_in <= '0;
    case (a)
      mpio_pkg::OFF_OSC_LATCH:   m_osc = d;
      mpio_pkg::OFF_TIMER_LATCH: m_tl = d;
      mpio_pkg::OFF_SEG_A_LATCH: m_sa = d;
      mpio_pkg::OFF_ANA_LATCH:   m_al = d;
      mpio_pkg::OFF_SEG_B_LATCH: m_sb = d;
      mpio_pkg::OFF_ANA_DIR:     m_ad = d;
      mpio_pkg::OFF_CTL:         m_ctl = d;
      mpio_pkg::OFF_TIMER_TYPE:  m_tt = d;
      mpio_pkg::OFF_SEG_A_LCD:   m_sal = d;
      mpio_pkg::OFF_SEG_B_LCD:   m_sbl = d;
      mpio_pkg::OFF_STATUS:      if (d[0]) m_flag = 1'b0;
      default:                   ;
    endcase
  endtask

  // Reads go out back to back; each answer is taken in the cycle after its request.
  task automatic check_all();
    logic [7:0] pe, pm;
    chk("osc pins", l_osc, {5'h00, lv_osc}, 8'h07);
    chk("timer pins", l_tim, {4'h0, lv_tim}, 8'h0F);
    chk("seg a pins", l_sa, lv_sa, 8'hFF);
    chk("seg b pins", l_sb, lv_sb, 8'hFF);
    chk("ana pins", l_an, lv_an, 8'hFF);
    chk("crystal", {7'h00, m_ctl[0]}, {7'h00, xtal_en}, 8'h01);
    chk("ana select", ~m_ad & ~m_al & ~{8{m_ctl[1]}}, an_sel, 8'hFF);
    chk("ana func", l_an & (m_ad | m_al), an_func, 8'hFF);
    for (int i = 0; i <= rl.size(); i++) begin
      @(posedge clk_in);
      if (i < rl.size()) bus_in <= '{wr: 1'b0, rd: 1'b1, addr: rl[i], wdata: 8'h00};
      else bus_in <= '0;
      @(negedge clk_in);
      if (i > 0) chk($sformatf("reg %h", rl[i-1]), pe, rdata, pm);
      if (i < rl.size()) begin
        pe = exp_rd(rl[i]);
        pm = msk(rl[i]);
      end
    end
    @(negedge clk_in);
    chk("idle rdata", 8'h00, rdata, 8'hFF);
  endtask

  task automatic set_ext(input logic [7:0] a, b, c, d, e);
    ee_osc <= a & ~d_osc;
    ee_tim <= b & ~d_tim;
    ee_sa <= c & ~d_sa;
    ee_sb <= d & ~d_sb;
    ee_an <= e & ~m_ad;
    repeat (3) @(posedge clk_in);
    calc();
  endtask

  initial begin
    repeat (30000) @(posedge clk_in);
    miscompares++;
    close_out();
  end

  initial begin
    logic [7:0] a, d;
    {ee_osc, ee_tim, ee_sa, ee_sb, ee_an} = '0;
    {xe_osc, xe_tim, xe_sa, xe_sb, xe_an} = '0;
    {m_osc, m_tl, m_sa, m_sb} = {4{mpio_pkg::RST_ONES}};
    {m_tt, m_sal, m_sbl, m_al, m_ad} = '0;
    m_ctl = mpio_pkg::RST_CTL;
    {m_flag, prev0} = 2'b01;
    wl = '{mpio_pkg::OFF_OSC_LATCH, mpio_pkg::OFF_TIMER_LATCH, mpio_pkg::OFF_SEG_A_LATCH,
           mpio_pkg::OFF_ANA_LATCH, mpio_pkg::OFF_SEG_B_LATCH, mpio_pkg::OFF_ANA_DIR,
           mpio_pkg::OFF_CTL, mpio_pkg::OFF_TIMER_TYPE, mpio_pkg::OFF_SEG_A_LCD,
           mpio_pkg::OFF_SEG_B_LCD, mpio_pkg::OFF_STATUS, mpio_pkg::OFF_TIMER_PIN, 8'h01};
    rl = '{mpio_pkg::OFF_OSC_PIN, mpio_pkg::OFF_SEG_A_PIN, mpio_pkg::OFF_SEG_B_PIN, 8'hFF};
    foreach (wl[i]) rl.push_back(wl[i]);
    void'($urandom(32'h8496F8FF));
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    calc();
    check_all();
    wr(mpio_pkg::OFF_TIMER_LATCH, 8'hFF);
    wr(mpio_pkg::OFF_TIMER_TYPE, 8'h00);
    for (int n = 0; n < 60; n++) begin
      set_ext(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      a = wl[$urandom % wl.size()];
      d = 8'($urandom);
      if (a == mpio_pkg::OFF_ANA_DIR && !m_ctl[1]) d = d & m_al;
      wr(a, d);
      repeat (3) @(posedge clk_in);
      calc();
      stop_mode <= 1'($urandom);
      alt_d <= 4'($urandom);
      alt_e <= 4'($urandom);
      lcd_a <= 8'($urandom);
      lcd_b <= 8'($urandom);
      repeat (3) @(posedge clk_in);
      calc();
      {xe_osc, xe_tim, xe_sa, xe_sb} <= $urandom;
      xe_an <= 8'($urandom);
      set_ext(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
      check_all();
    end
    close_out();
  end
endmodule
